// >>> hw/sar_cfg.svh
// Purpose: Shared constants of the sample readout port
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes: Mode encodings live as enums in sar_pkg
//
// Overview of operation
// RULE_01: Trigger rising edge starts a conversion
// RULE_02: Chip select after conversion loads result
// RULE_03: Host times first-zone chip select correctly
// RULE_04: Host quiet before trigger rising edge
// RULE_05: Host quiet after trigger rising edge
// RULE_06: Host asserts second-zone select early enough
// RULE_07: Late select lets next sample overwrite
// RULE_08: Clock source codes: host, echo, oscillator
// RULE_09: Host clock mode drives busy status
// RULE_10: Timer-based host waits after trigger edge
// RULE_11: Averaging host waits after final trigger
// RULE_12: Echo mode returns host clock, no status
// RULE_13: Echo or oscillator host waits after trigger
// RULE_14: Echo clock aligned with lane transitions
// RULE_15: Oscillator clock divided by 1, 2, 4
// RULE_16: Pulse count computed and readable
// RULE_17: Host keeps serial clock idle in oscillator mode
// RULE_18: Rate code 0 single, 1 double
// RULE_19: Double rate only in echo, oscillator
// RULE_20: Lane code 0 one lane, 1 two
// RULE_21: Two lanes split bits, halve pulses
// RULE_22: Lane code 2 selects four lanes
// RULE_23: Lanes change on rising, double both edges; host clock mode shifts the lanes on the fall
// RULE_24: Busy high during conversion in host mode
// RULE_25: Lanes shift only while select low
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

// Clock period of mclk_i
`define SAR_CLK_NS 10
// Conversion time, typical
`define SAR_T_CONV_NS 282
// Least time, rounded up to whole cycles
`define SAR_CONV_CYC ((`SAR_T_CONV_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
// Select must lead end of conversion by this much
`define SAR_T_LATE_NS 25
`define SAR_LATE_CYC ((`SAR_T_LATE_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
// Sample word and buffer shape
`define SAR_WORD_BITS 24
`define SAR_FIFO_DEPTH 4
// Pin synchroniser reset levels {clock, select_n, trigger}
`define SAR_PIN_RST 3'h2

`endif

// >>> hw/sar_pkg.sv
// Purpose: Types of the sample readout port
// Assumes: Used with sar_cfg.svh
// Notes: Codes match the configuration port encodings
package sar_pkg;

    // Bit clock source
    typedef enum logic [1:0] {
        SAR_CLK_HOST = 2'h0,
        SAR_CLK_ECHO = 2'h1,
        SAR_CLK_OSC = 2'h2
    } sar_clk_e;

    // Active output lane count
    typedef enum logic [1:0] {
        SAR_LANE1 = 2'h0,
        SAR_LANE2 = 2'h1,
        SAR_LANE4 = 2'h2
    } sar_lane_e;

    // Oscillator divisor
    typedef enum logic [1:0] {
        SAR_DIV1 = 2'h0,
        SAR_DIV2 = 2'h1,
        SAR_DIV4 = 2'h2
    } sar_div_e;

    // Readout sequencer
    typedef enum logic [1:0] {
        SAR_ST_IDLE = 2'h0,
        SAR_ST_SHIFT = 2'h1,
        SAR_ST_DONE = 2'h2
    } sar_st_e;

endpackage : sar_pkg

// >>> hw/sar_fifo.sv
// Purpose: Result buffer between converter and readout
// Assumes: DEPTH is a power of two
// Notes: Read data is the head word, valid with out_valid_o
`timescale 1ns/1ps

module sar_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 4
)
(
    input logic mclk_i,
    input logic rst_i,
    input logic in_valid_i,
    output logic in_ready_o,
    input logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = mem[rd_ff];

    // Storage, no reset needed on data
    always_ff @(posedge mclk_i)
    begin
        if (push)
            mem[wr_ff] <= in_data_i;
    end

    // Pointers and count
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ff <= wr_ff + 1'b1;
            if (pop)
                rd_ff <= rd_ff + 1'b1;
            if (push && !pop)
                cnt_ff <= cnt_ff + 1'b1;
            else if (pop && !push)
                cnt_ff <= cnt_ff - 1'b1;
        end
    end

endmodule : sar_fifo

// >>> hw/sar_conv.sv
// Purpose: Conversion timer and result capture
// Assumes: Trigger edge already synchronised
// Notes: A retrigger restarts the timer
`timescale 1ns/1ps
`include "sar_cfg.svh"

module sar_conv #(
    parameter int N = `SAR_WORD_BITS,
    parameter int CYC = `SAR_CONV_CYC,
    parameter int LATE = `SAR_LATE_CYC
)
(
    input logic mclk_i,
    input logic rst_i,
    input logic trig_rise_i,
    input logic [N-1:0] sample_i,
    input logic res_ready_i,
    output logic busy_o,
    output logic near_end_o,
    output logic res_valid_o,
    output logic [N-1:0] res_data_o
);
    logic [8:0] cnt_ff;
    logic busy_ff;

    assign busy_o = busy_ff;
    // Inside the last window a new select cannot claim the old word
    assign near_end_o = busy_ff & (cnt_ff <= 9'(LATE)); // RULE_07

    // Conversion countdown
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
        end
        else if (trig_rise_i)
        begin
            cnt_ff <= 9'(CYC); // RULE_01
            busy_ff <= 1'b1; // RULE_24
        end
        else if (busy_ff)
        begin
            cnt_ff <= cnt_ff - 1'b1;
            busy_ff <= (cnt_ff != 9'h001); // RULE_24
        end
    end

    // Result capture; a stalled result is replaced by a newer one
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            res_valid_o <= 1'b0;
            res_data_o <= '0;
        end
        else if (busy_ff && cnt_ff == 9'h001 && !trig_rise_i)
        begin
            res_valid_o <= 1'b1;
            res_data_o <= sample_i;
        end
        else if (res_ready_i)
            res_valid_o <= 1'b0;
    end

    AST_CONV_START: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_01
        trig_rise_i |=> busy_o) else $error("conversion not started");
    AST_RESULT_AT_END: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_24
        $fell(busy_o) |-> res_valid_o) else $error("no result at end");
    AST_NEAR_IN_BUSY: assert property (@(posedge mclk_i) // RULE_07
        disable iff (rst_i || trig_rise_i)
        $rose(near_end_o) |-> ##LATE $fell(busy_o)) else $error("late window length wrong");

endmodule : sar_conv

// >>> hw/sar_port.sv
// Purpose: Sample readout port, trigger to serial lanes
// Assumes: Pins are asynchronous and pass two flip-flops
// Notes: Serial clock is oversampled, so it must stay well below mclk_i
`timescale 1ns/1ps
`include "sar_cfg.svh"

module sar_port #(
    parameter int N = `SAR_WORD_BITS,
    parameter int DEPTH = `SAR_FIFO_DEPTH
)
(
    input logic mclk_i,
    input logic rst_i,
    input logic conversion_trigger_i,
    input logic cs_n_i,
    input logic sck_i,
    input logic [N-1:0] sample_i,
    input logic [1:0] clock_source_select_i,
    input logic [1:0] oscillator_divisor_i,
    input logic data_rate_select_i,
    input logic [1:0] lane_count_select_i,
    output logic busy_or_clock_out_o,
    output logic [3:0] serial_output_lanes_o,
    output logic [7:0] clock_pulse_count_o
);

    // Lane code to log2 of lane count
    function automatic logic [1:0] lane_log2(input logic [1:0] sel);
        case (sel)
            sar_pkg::SAR_LANE2: lane_log2 = 2'h1;
            sar_pkg::SAR_LANE4: lane_log2 = 2'h2;
            default: lane_log2 = 2'h0;
        endcase
    endfunction : lane_log2

    // Divisor code to last count of the divider
    function automatic logic [1:0] div_last(input logic [1:0] sel);
        case (sel)
            sar_pkg::SAR_DIV2: div_last = 2'h1;
            sar_pkg::SAR_DIV4: div_last = 2'h3;
            default: div_last = 2'h0;
        endcase
    endfunction : div_last

    // Clock source code; the unused code falls back to host clock
    function automatic sar_pkg::sar_clk_e mode_of(input logic [1:0] sel);
        case (sel)
            sar_pkg::SAR_CLK_ECHO: mode_of = sar_pkg::SAR_CLK_ECHO;
            sar_pkg::SAR_CLK_OSC: mode_of = sar_pkg::SAR_CLK_OSC;
            default: mode_of = sar_pkg::SAR_CLK_HOST;
        endcase
    endfunction : mode_of

    // Pin synchronisers {clock, select_n, trigger}
    logic [2:0] pin_w;
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] prev_ff;
    // Decoded pin events
    logic trig_rise;
    logic cs_low;
    logic sck_rise;
    logic sck_fall;
    // Configuration decode
    sar_pkg::sar_clk_e mode;
    logic ddr;
    logic [1:0] lsh;
    logic [2:0] nl;
    logic [7:0] steps;
    logic [7:0] pulses;
    logic [7:0] cpc_ff;
    // Converter and buffer handshake
    logic busy;
    logic near_end;
    logic res_valid;
    logic [N-1:0] res_data;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic [N-1:0] f_out_data;
    logic load;
    logic stale;
    // Readout state
    sar_pkg::sar_st_e st_ff;
    logic [N-1:0] sr_ff;
    logic [N-1:0] nxt_sr;
    logic [7:0] remain_ff;
    logic first_ff;
    logic edge_evt;
    logic shift;
    logic nxt_act;
    logic [3:0] nxt_lane;
    logic [3:0] lanes_ff;
    // Internal oscillator
    logic [1:0] div_ff;
    logic osc_ff;
    logic nxt_osc;
    logic [7:0] oscl_ff;
    logic osc_run;
    logic osc_tog;
    logic bco_ff;

    assign pin_w = {sck_i, cs_n_i, conversion_trigger_i};

    // Two flops per pin; only the second stage feeds logic
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge mclk_i)
            begin
                if (rst_i)
                begin
                    sync1_ff[gi] <= 1'(`SAR_PIN_RST >> gi);
                    sync2_ff[gi] <= 1'(`SAR_PIN_RST >> gi);
                end
                else
                begin
                    sync1_ff[gi] <= pin_w[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    // Delayed copy for edge detection
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            prev_ff <= `SAR_PIN_RST;
        else
            prev_ff <= sync2_ff;
    end

    assign trig_rise = sync2_ff[0] & ~prev_ff[0]; // RULE_01
    assign cs_low = ~sync2_ff[1];
    assign sck_rise = sync2_ff[2] & ~prev_ff[2];
    assign sck_fall = ~sync2_ff[2] & prev_ff[2];

    // Mode decode
    assign mode = mode_of(clock_source_select_i); // RULE_08
    // Double rate is refused with the host clock
    assign ddr = data_rate_select_i & (mode != sar_pkg::SAR_CLK_HOST); // RULE_18 RULE_19
    assign lsh = lane_log2(lane_count_select_i); // RULE_20 RULE_22
    assign nl = 3'h1 << lsh;
    // Bits per lane, then clock pulses for the chosen rate
    assign steps = 8'(N) >> lsh; // RULE_21 RULE_22
    assign pulses = ddr ? (steps >> 1) : steps; // RULE_16 RULE_19

    // Readable pulse count
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            cpc_ff <= '0;
        else
            cpc_ff <= pulses; // RULE_16
    end

    assign clock_pulse_count_o = cpc_ff;

    // Conversion timer
    sar_conv #(
        .N(N)
    ) u_conv (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .trig_rise_i(trig_rise),
        .sample_i(sample_i),
        .res_ready_i(f_in_ready),
        .busy_o(busy),
        .near_end_o(near_end),
        .res_valid_o(res_valid),
        .res_data_o(res_data)
    );

    // Results wait here; a full buffer stalls the converter output
    sar_fifo #(
        .W(N),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(res_valid),
        .in_ready_o(f_in_ready),
        .in_data_i(res_data),
        .out_valid_o(f_out_valid),
        .out_ready_i(f_out_ready),
        .out_data_o(f_out_data)
    );

    // Load only if select came before the late window and no newer word is landing
    assign load = (st_ff == sar_pkg::SAR_ST_IDLE) & cs_low & f_out_valid
        & ~near_end & ~res_valid; // RULE_02 RULE_07
    // An unclaimed word is dropped when the next result lands
    assign stale = res_valid & f_in_ready & f_out_valid & ~load; // RULE_07
    assign f_out_ready = load | stale;

    // Oscillator runs only during a readout
    assign osc_run = (st_ff != sar_pkg::SAR_ST_IDLE) & cs_low
        & (mode == sar_pkg::SAR_CLK_OSC) & (oscl_ff != 8'h00);
    assign osc_tog = osc_run & (div_ff == div_last(oscillator_divisor_i)); // RULE_15
    assign nxt_osc = osc_tog ? ~osc_ff : osc_ff;

    // Which clock edges move the lanes
    always_comb
    begin
        edge_evt = 1'b0;
        case (mode)
            sar_pkg::SAR_CLK_ECHO: edge_evt = sck_rise | (ddr & sck_fall); // RULE_23
            sar_pkg::SAR_CLK_OSC: edge_evt = osc_tog & (~osc_ff | ddr); // RULE_23
            default: edge_evt = sck_fall;
        endcase
    end

    // First edge in echo and oscillator modes presents the top bit
    assign shift = (st_ff == sar_pkg::SAR_ST_SHIFT) & edge_evt & ~first_ff
        & (remain_ff != 8'h00);

    // Shift register next value
    always_comb
    begin
        nxt_sr = sr_ff;
        if (load)
            nxt_sr = f_out_data; // RULE_02
        else if (shift)
            nxt_sr = sr_ff << nl; // RULE_21 RULE_22
    end

    assign nxt_act = cs_low & ((st_ff != sar_pkg::SAR_ST_IDLE) | load);

    // Lane k carries the k-th bit below the top each step
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            assign nxt_lane[gi] = nxt_act & (gi < nl) & nxt_sr[N-1-gi]; // RULE_25
        end
    endgenerate

    // Sequencer
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            st_ff <= sar_pkg::SAR_ST_IDLE;
        else if (!cs_low)
            st_ff <= sar_pkg::SAR_ST_IDLE; // RULE_25
        else
        begin
            case (st_ff)
                sar_pkg::SAR_ST_IDLE:
                    if (load)
                        st_ff <= sar_pkg::SAR_ST_SHIFT;
                sar_pkg::SAR_ST_SHIFT:
                    if (shift && remain_ff == 8'h01)
                        st_ff <= sar_pkg::SAR_ST_DONE;
                // One word per select; wait for release
                sar_pkg::SAR_ST_DONE:
                    st_ff <= sar_pkg::SAR_ST_DONE;
                default:
                    st_ff <= sar_pkg::SAR_ST_IDLE;
            endcase
        end
    end

    // Data path and bit counting
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            sr_ff <= '0;
            remain_ff <= '0;
            first_ff <= 1'b0;
            lanes_ff <= '0;
        end
        else
        begin
            sr_ff <= nxt_sr;
            lanes_ff <= nxt_lane; // RULE_14 RULE_25
            if (load)
            begin
                remain_ff <= steps - 8'h01;
                first_ff <= (mode != sar_pkg::SAR_CLK_HOST); // RULE_23
            end
            else
            begin
                if (shift)
                    remain_ff <= remain_ff - 8'h01;
                if (edge_evt)
                    first_ff <= 1'b0;
            end
        end
    end

    // Oscillator divider and edge budget
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || !cs_low)
        begin
            div_ff <= '0;
            osc_ff <= 1'b0;
            oscl_ff <= '0;
        end
        else if (load)
        begin
            div_ff <= '0;
            osc_ff <= 1'b0;
            oscl_ff <= pulses << 1; // RULE_16
        end
        else if (osc_run)
        begin
            div_ff <= osc_tog ? 2'h0 : div_ff + 2'h1; // RULE_15
            osc_ff <= nxt_osc;
            if (osc_tog)
                oscl_ff <= oscl_ff - 8'h01;
        end
    end

    // Shared pin: busy, echoed clock or oscillator clock
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            bco_ff <= 1'b0;
        else
        begin
            case (mode)
                sar_pkg::SAR_CLK_ECHO: bco_ff <= sync2_ff[2]; // RULE_12 RULE_14
                sar_pkg::SAR_CLK_OSC: bco_ff <= nxt_osc; // RULE_15
                default: bco_ff <= busy; // RULE_09 RULE_24
            endcase
        end
    end

    assign busy_or_clock_out_o = bco_ff;
    assign serial_output_lanes_o = lanes_ff;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // A load followed by the shifting state
    sequence s_load;
        load ##1 (st_ff == sar_pkg::SAR_ST_SHIFT);
    endsequence

    AST_LOAD_WORD: assert property ( // RULE_02
        s_load |-> lanes_ff[0] == $past(f_out_data[N-1]))
        else $error("first bit not the loaded top bit");
    AST_IDLE_LANES: assert property ( // RULE_25
        !cs_low |=> lanes_ff == 4'h0)
        else $error("lanes active with select high");
    AST_BUSY_PIN: assert property ( // RULE_09
        (mode == sar_pkg::SAR_CLK_HOST) |=> bco_ff == $past(busy))
        else $error("busy not on shared pin");
    AST_ECHO_CLK: assert property ( // RULE_12
        (mode == sar_pkg::SAR_CLK_ECHO) |=> bco_ff == $past(sync2_ff[2]))
        else $error("clock not echoed");
    AST_OSC_TOGGLE: assert property ( // RULE_15
        osc_tog |=> bco_ff == !$past(osc_ff))
        else $error("oscillator clock did not toggle");
    AST_NO_DDR_HOST: assert property ( // RULE_19
        (mode == sar_pkg::SAR_CLK_HOST && st_ff == sar_pkg::SAR_ST_SHIFT && cs_low && !sck_fall)
        |=> $stable(lanes_ff))
        else $error("lanes moved off the host clock fall");
    AST_PULSES_ONE: assert property ( // RULE_16
        (lane_count_select_i == sar_pkg::SAR_LANE1 && !ddr) |=> cpc_ff == 8'(N))
        else $error("single lane pulse count wrong");
    AST_PULSES_FOUR: assert property ( // RULE_22
        (lane_count_select_i == sar_pkg::SAR_LANE4 && ddr) |=> cpc_ff == 8'(N / 8))
        else $error("four lane double rate count wrong");
    AST_STALE_DROP: assert property ( // RULE_07
        (res_valid && f_in_ready && f_out_valid) |=> f_out_data == $past(res_data))
        else $error("unclaimed word not replaced");
    AST_UPPER_IDLE: assert property ( // RULE_20
        (lane_count_select_i == sar_pkg::SAR_LANE1) |=> lanes_ff[3:1] == 3'h0
        || $past(lane_count_select_i) != lane_count_select_i)
        else $error("extra lanes driven in one-lane mode");

endmodule : sar_port

// >>> dv/sar_host_model.sv
// Purpose: Host controller model that reads sample words off the output lanes
// Assumes: Lanes and returned clock are registered on mclk_i and change together
// Notes: Host serial clock half period is 8 mclk cycles, well under the oversampling limit
`timescale 1ns/1ps

module sar_host_model #(
    parameter int N = 24
)
(
    input wire logic mclk_i,
    input wire logic start_i,
    input wire logic [1:0] clk_sel_i,
    input wire logic ddr_i,
    input wire logic [1:0] lane_sel_i,
    input wire logic [7:0] pulses_i,
    input wire logic bco_i,
    input wire logic [3:0] lanes_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic [N-1:0] word_o,
    output logic done_o
);
    // Edge source: own clock in host clock mode, returned clock otherwise
    wire logic src = (clk_sel_i == 2'h0) ? sck_o : bco_i;
    logic prev_ff;
    // Lane steps collected in the current transfer
    int got = 0;

    // Idle levels: deselected, clock low
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        word_o = '0;
        done_o = 1'b0;
        prev_ff = 1'b0;
    end

    // Sample on rising source edges, both edges at double rate outside host clock mode; in host clock mode the lanes change on the fall
    always @(posedge mclk_i)
    begin
        prev_ff <= src;
        // A start pulse clears the previous word
        if (start_i)
        begin
            got <= 0;
            word_o <= '0;
        end
        else if (!cs_n_o && got < (N >> lane_sel_i) && src !== prev_ff &&
            (src || (ddr_i && clk_sel_i != 2'h0)))
        begin
            got <= got + 1;
            // Lane 0 carries the upper bit of each step
            case (lane_sel_i)
                2'h1: word_o <= {word_o[N-3:0], lanes_i[0], lanes_i[1]};
                2'h2: word_o <= {word_o[N-5:0], lanes_i[0], lanes_i[1], lanes_i[2], lanes_i[3]};
                default: word_o <= {word_o[N-2:0], lanes_i[0]};
            endcase
        end
    end

    // One transfer per start pulse; the bench only starts outside the quiet zones
    always
    begin
        @(posedge mclk_i);
        if (start_i)
        begin
            done_o <= 1'b0;
            cs_n_o <= 1'b0;
            repeat (8) @(posedge mclk_i);
            // Oscillator mode: our own clock stays idle
            if (clk_sel_i != 2'h2)
            begin
                repeat (pulses_i)
                begin
                    sck_o <= 1'b1;
                    repeat (8) @(posedge mclk_i);
                    sck_o <= 1'b0;
                    repeat (8) @(posedge mclk_i);
                end
            end
            // Bounded wait, so a silent device cannot hang the model
            for (int i = 0; i < 400 && got < (N >> lane_sel_i); i++)
                @(posedge mclk_i);
            repeat (4) @(posedge mclk_i);
            cs_n_o <= 1'b1;
            done_o <= 1'b1;
        end
    end
endmodule : sar_host_model

// >>> dv/adc_sample_readout_port_tb.sv
// Purpose: Self-checking bench of the sample readout port
// Assumes: Host model on the serial side, all configuration ports driven here
// Notes: Expected words and counts are worked out here, never read back from the port
`timescale 1ns/1ps

module adc_sample_readout_port_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic trig = 1'b0;
    logic start = 1'b0;
    logic ddr = 1'b0;
    logic [1:0] clk_sel = 2'h0;
    logic [1:0] div = 2'h0;
    logic [1:0] lane = 2'h0;
    logic [7:0] pulses = 8'h18;
    logic [23:0] sample = 24'h000000;
    logic bco;
    logic [3:0] lanes;
    logic [7:0] cnt;
    logic cs_n;
    logic sck;
    logic [23:0] word;
    logic done;
    logic [7:0] tmp_hi;
    // Length of the current and of the last high run on the shared pin
    logic [7:0] run_ff = 8'h00;
    logic [7:0] last_run_ff = 8'h00;
    int err_total = 0;
    int compares = 0;

    // 100 MHz clock
    initial
    begin
        forever #5 mclk = ~mclk;
    end

    // High-run meter: busy width in host mode, clock half period otherwise
    always @(posedge mclk)
    begin
        if (bco === 1'b1)
        begin
            run_ff <= run_ff + 8'h01;
        end
        else if (run_ff != 8'h00)
        begin
            last_run_ff <= run_ff;
            run_ff <= 8'h00;
        end
    end

    sar_port sar_port_inst (
        .mclk_i(mclk), .rst_i(rst), .conversion_trigger_i(trig), .cs_n_i(cs_n), .sck_i(sck),
        .sample_i(sample), .clock_source_select_i(clk_sel), .oscillator_divisor_i(div),
        .data_rate_select_i(ddr), .lane_count_select_i(lane), .busy_or_clock_out_o(bco),
        .serial_output_lanes_o(lanes), .clock_pulse_count_o(cnt));

    sar_host_model sar_host_model_inst (
        .mclk_i(mclk), .start_i(start), .clk_sel_i(clk_sel), .ddr_i(ddr), .lane_sel_i(lane),
        .pulses_i(pulses), .bco_i(bco), .lanes_i(lanes), .cs_n_o(cs_n), .sck_o(sck),
        .word_o(word), .done_o(done));

    task print_verdict;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task chk_word(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task chk_num(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_num

    // Trigger pulse of 2 cycles, then count busy-high cycles over the gap
    task convert(input logic [23:0] val, input int gap, output logic [7:0] hi);
        hi = 8'h00;
        repeat (3) @(posedge mclk);
        sample <= val;
        trig <= 1'b1;
        repeat (2) @(posedge mclk);
        trig <= 1'b0;
        repeat (gap)
        begin
            @(posedge mclk);
            if (bco === 1'b1)
                hi = hi + 8'h01;
        end
    endtask : convert

    // One host transfer, bounded so a stuck port ends the run
    task read_word;
        int i;
        @(posedge mclk);
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        for (i = 0; i < 3000; i++)
        begin
            @(posedge mclk);
            if (done === 1'b1)
                break;
        end
        if (done !== 1'b1)
        begin
            err_total++;
            print_verdict();
        end
    endtask : read_word

    // Configure, convert, read back and check one mode combination
    task run_cfg(input logic [1:0] c, input logic d, input logic [1:0] l, input logic [1:0] v,
                 input logic [23:0] val);
        logic [7:0] hi;
        @(posedge mclk);
        clk_sel <= c;
        ddr <= d;
        lane <= l;
        div <= v;
        pulses <= 8'h18 >> (l + (d & (c != 2'h0)));
        convert(val, 45, hi);
        chk_num(hi, (c == 2'h0) ? 8'h1D : 8'h00);
        chk_num(cnt, pulses);
        read_word();
        chk_word(word, val);
        chk_num(last_run_ff, (c == 2'h0) ? 8'h1D : (c == 2'h1) ? 8'h08 : 8'h01 << v);
        repeat (3) @(posedge mclk);
        chk_num({4'h0, lanes}, 8'h00);
    endtask : run_cfg

    // Main sequence
    initial
    begin
        repeat (9) @(posedge mclk);
        chk_num(cnt, 8'h00);
        chk_num({3'h0, bco, lanes}, 8'h00);
        @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        run_cfg(sar_pkg::SAR_CLK_HOST, 1'b0, sar_pkg::SAR_LANE1, sar_pkg::SAR_DIV1, 24'hA5C396);
        run_cfg(sar_pkg::SAR_CLK_HOST, 1'b0, sar_pkg::SAR_LANE2, sar_pkg::SAR_DIV1, 24'h5A3C69);
        run_cfg(sar_pkg::SAR_CLK_HOST, 1'b0, sar_pkg::SAR_LANE4, sar_pkg::SAR_DIV1, 24'h1248E7);
        run_cfg(sar_pkg::SAR_CLK_ECHO, 1'b0, sar_pkg::SAR_LANE1, sar_pkg::SAR_DIV1, 24'hF00D81);
        run_cfg(sar_pkg::SAR_CLK_ECHO, 1'b1, sar_pkg::SAR_LANE2, sar_pkg::SAR_DIV1, 24'h6B2D4E);
        run_cfg(sar_pkg::SAR_CLK_OSC, 1'b0, sar_pkg::SAR_LANE1, sar_pkg::SAR_DIV1, 24'h3C5A96);
        run_cfg(sar_pkg::SAR_CLK_OSC, 1'b1, sar_pkg::SAR_LANE4, sar_pkg::SAR_DIV2, 24'hC71E2B);
        run_cfg(sar_pkg::SAR_CLK_OSC, 1'b0, sar_pkg::SAR_LANE2, sar_pkg::SAR_DIV4, 24'h9E0F73);
        run_cfg(sar_pkg::SAR_CLK_OSC, 1'b1, sar_pkg::SAR_LANE1, sar_pkg::SAR_DIV4, 24'h2D6C15);
        run_cfg(sar_pkg::SAR_CLK_HOST, 1'b1, sar_pkg::SAR_LANE2, sar_pkg::SAR_DIV1, 24'h36C9A5);
        run_cfg(sar_pkg::SAR_CLK_HOST, 1'b0, sar_pkg::SAR_LANE1, sar_pkg::SAR_DIV1, 24'h7E81C4);
        // Select early in the next conversion still gets the older word
        convert(24'h123456, 45, tmp_hi);
        convert(24'h89ABCD, 3, tmp_hi);
        read_word();
        chk_word(word, 24'h123456);
        read_word();
        chk_word(word, 24'h89ABCD);
        // A word never selected is replaced by the newer one
        convert(24'h0F1E2D, 45, tmp_hi);
        convert(24'hC3B2A1, 45, tmp_hi);
        read_word();
        chk_word(word, 24'hC3B2A1);
        // Select inside the late window gets the newer word
        convert(24'h4B1E77, 45, tmp_hi);
        convert(24'hB4E188, 24, tmp_hi);
        read_word();
        chk_word(word, 24'hB4E188);
        print_verdict();
    end
endmodule : adc_sample_readout_port_tb
